// [hw/adc_monitor_sequencer.sv]
/*
 * monitoring converter sequencer: steps one converter over five channels,
 * keeps 8-bit results, fresh flags and calibration constants behind an
 * AXI4-Lite slave. assumes an external converter that answers each
 * conv_start pulse with one conv_done pulse, well inside a pass interval.
 */
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: channels are converted one at a time in a fixed order, never together.
// RULE2: a full pass over all five channels completes within one conversion interval.
// RULE3: only in maker mode may the supply slot measure another node, else it measures supply.
// RULE4: the three-bit source field picks supply, analog supply, bias, modulation or three DACs.
// RULE5: pin sources use a coarse step and DAC sources a fine step, flagged with the result.
// RULE6: temperature and supply results come out already calibrated in two-byte form; here they too are one code byte in the high byte with a zero low byte.
// RULE7: bias, transmit and receive results sit in the high byte with a zero low byte.
// RULE8: bias code 255 means 300 mV on the sense resistor, linear in between.
// RULE9: transmit sense is referred to ground or analog supply by the polarity bit.
// RULE10: the gain bit narrows the transmit channel to a quarter of the reference.
// RULE11: calibration slopes, offsets and coefficients are stored for the host to read back.
// RULE12: the host should program unity slope and zero offset for temperature and supply.
// RULE13: the host finds bias offset with the transmitter disabled and stores its negative.
// RULE14: the latest results stay readable and update as each conversion completes.
// RULE15: a read-only flag per parameter marks which results are fresh.
// RULE16: after the last channel the sequencer wraps to the first and keeps running; here it waits in ST_IDLE for the next interval expiry.
module adc_monitor_sequencer
   import adc_mon_pkg::*;
#(
   parameter int unsigned CONV_INTERVAL = adc_mon_pkg::TCONV_CYCLES
) (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [7:0]              awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [7:0]              araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   output logic                         conv_start,
   output adc_mon_pkg::chan_e           conv_channel,
   output logic [2:0]                   aux_source_select,
   output logic                         tx_gain,
   output logic                         bias_reference_polarity,
   input  wire logic                    conv_done,
   input  wire logic [7:0]              conv_data
);

   import adc_mon_pkg::*;

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q, rd_stage_q;
   logic        aw_hold_q, w_hold_q;
   logic [7:0]  wr_addr_q, rd_addr_q;
   logic [31:0] wr_data_q, rdata_q, cal_rdata;
   logic [3:0]  wr_strb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [5:0]  cfg_q;
   logic [7:0]  result_q [NUM_CH];
   logic [NUM_CH-1:0] ready_q;
   logic        supply_fine_q;
   seq_state_e  state_q;
   chan_e       chan_q;
   logic [15:0] interval_q;
   logic        conv_start_q, tx_gain_q, refpol_q;
   logic [2:0]  aux_q;
   logic        wr_fire, rd_take, store, pass_go, rd_cal, wr_cal;
   logic [5:0]  rd_idx, wr_idx;
   logic [3:0]  cal_raddr, cal_waddr;

   assign wr_fire  = aw_hold_q && w_hold_q && !bvalid_q;
   assign rd_take  = arvalid && arready_q;
   assign store    = (state_q == ST_WAIT) && conv_done && !conv_start_q;
   assign pass_go  = (interval_q == 16'h0000);
   assign rd_idx   = araddr[7:2];
   assign wr_idx   = wr_addr_q[7:2];
   assign rd_cal   = (araddr >= REG_CAL_BASE) && (rd_idx < 6'(REG_CAL_BASE[7:2] + CAL_WORDS));
   assign wr_cal   = (wr_addr_q >= REG_CAL_BASE) && (wr_idx < 6'(REG_CAL_BASE[7:2] + CAL_WORDS));
   assign cal_raddr = 4'(rd_idx - REG_CAL_BASE[7:2]);
   assign cal_waddr = 4'(wr_idx - REG_CAL_BASE[7:2]);

   // ------------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------------
   // address and data are held independently; the write lands once both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         wr_addr_q <= 8'h00;
         wr_data_q <= 32'h0000_0000;
         wr_strb_q <= 4'h0;
      end else begin
         if (awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_hold_q <= 1'b1;
            wr_addr_q <= awaddr;
         end
         if (wvalid && wready_q) begin
            wready_q  <= 1'b0;
            w_hold_q  <= 1'b1;
            wr_data_q <= wdata;
            wr_strb_q <= wstrb;
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= (wr_addr_q == REG_CONFIG || wr_cal) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;  // one write at a time keeps ordering trivial
            wready_q  <= 1'b1;
         end
      end
   end

   // configuration byte, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= CFG_RESET;
      end else if (wr_fire && wr_addr_q == REG_CONFIG && wr_strb_q[0]) begin
         cfg_q <= wr_data_q[5:0];
      end
   end

   // calibration constants kept for host read-back
   cal_store #(.WIDTH(32), .DEPTH(CAL_WORDS), .AW(4)) u_cal (  // RULE11
      .aclk    (aclk),
      .we      (wr_fire && wr_cal),
      .wstrb   (wr_strb_q),
      .waddr   (cal_waddr),
      .wdata   (wr_data_q),
      .raddr   (cal_raddr),
      .rdata_q (cal_rdata)
   );

   // ------------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------------
   // two-stage read so that calibration data come from the store's register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q  <= 1'b1;
         rd_stage_q <= 1'b0;
         rvalid_q   <= 1'b0;
         rdata_q    <= 32'h0000_0000;
         rresp_q    <= RESP_OKAY;
         rd_addr_q  <= 8'h00;
      end else begin
         rd_stage_q <= rd_take;
         if (rd_take) begin
            arready_q <= 1'b0;
            rd_addr_q <= rd_cal ? REG_CAL_BASE : araddr;
         end
         if (rd_stage_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
            if (rd_addr_q == REG_CONFIG) begin
               rdata_q <= {26'h0, cfg_q};
            end else if (rd_addr_q >= REG_RESULT0 && rd_addr_q < REG_READY) begin
               // high byte carries the code, low byte is zero for every channel
               rdata_q <= {16'h0, result_q[3'(rd_addr_q[7:2] - 6'h01)], 8'h00};  // RULE6 RULE7
            end else if (rd_addr_q == REG_READY) begin
               rdata_q <= {27'h0, ready_q};  // RULE15
            end else if (rd_addr_q == REG_STATUS) begin
               rdata_q <= {25'h0, supply_fine_q, aux_q, state_q, chan_q == CH_RXP};  // RULE5
            end else if (rd_addr_q == REG_CAL_BASE) begin
               rdata_q <= cal_rdata;
            end else begin
               rresp_q <= RESP_SLVERR;
            end
         end
         if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // pass timer and sequencer
   // ------------------------------------------------------------------
   // free-running interval; an expiry while the sequencer is in ST_IDLE launches one full pass
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interval_q <= 16'h0000;
      end else if (pass_go) begin
         interval_q <= 16'(CONV_INTERVAL - 1);  // RULE2
      end else begin
         interval_q <= interval_q - 16'h0001;
      end
   end

   // one conversion outstanding at a time, channels in fixed order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q      <= ST_IDLE;
         chan_q       <= CH_TEMP;
         conv_start_q <= 1'b0;
      end else begin
         conv_start_q <= (state_q == ST_START);  // RULE1
         case (state_q)
            ST_IDLE: begin
               if (pass_go) begin
                  state_q <= ST_START;
                  chan_q  <= CH_TEMP;
               end
            end
            ST_START: begin
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (store) begin
                  if (chan_q == CH_RXP) begin
                     state_q <= ST_IDLE;  // RULE16
                     chan_q  <= CH_TEMP;  // RULE16
                  end else begin
                     state_q <= ST_START;
                     chan_q  <= chan_e'(chan_q + 3'h1);  // RULE1
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // analog steering, registered from the configuration on every edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_q     <= AUX_SUPPLY_IN;
         tx_gain_q <= 1'b0;
         refpol_q  <= 1'b0;
      end else begin
         // without maker mode the slot is forced back to the supply input
         aux_q     <= cfg_q[CFG_MAKER_BIT] ? cfg_q[CFG_AUX_LSB +: 3] : AUX_SUPPLY_IN;  // RULE3 RULE4
         tx_gain_q <= cfg_q[CFG_GAIN_BIT];    // RULE10
         refpol_q  <= cfg_q[CFG_REFPOL_BIT];  // RULE9
      end
   end

   // ------------------------------------------------------------------
   // results and fresh flags
   // ------------------------------------------------------------------
   // bias code is ratiometric: full code 255 at the 300 mV full scale
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            result_q[i] <= 8'h00;
         end
         supply_fine_q <= 1'b0;
      end else if (store) begin
         result_q[chan_q] <= conv_data;  // RULE14 RULE8
         if (chan_q == CH_SUPPLY) begin
            supply_fine_q <= (aux_q >= AUX_LOOP_DAC);  // RULE5
         end
      end
   end

   // a read of a result clears its flag; a store in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_q <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (store && chan_q == chan_e'(i)) begin
               ready_q[i] <= 1'b1;  // RULE15
            end else if (rd_stage_q && rd_addr_q == 8'(REG_RESULT0 + 4 * i)) begin
               ready_q[i] <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign conv_start   = conv_start_q;
   assign conv_channel = chan_q;
   assign aux_source_select       = aux_q;
   assign tx_gain                 = tx_gain_q;
   assign bias_reference_polarity = refpol_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_start_then_wait: assert property (conv_start_q |-> state_q == ST_WAIT ##1 !conv_start_q) // RULE1
      else $error("conversion start not followed by a wait");
   a_channel_step: assert property (store && chan_q != CH_RXP |=> chan_q == $past(chan_q) + 3'h1 && state_q == ST_START ##1 conv_start_q) // RULE1
      else $error("channel did not step to the next one");
   a_pass_wrap: assert property (store && chan_q == CH_RXP |=> chan_q == CH_TEMP && state_q == ST_IDLE) // RULE16
      else $error("sequencer did not wrap after the last channel");
   a_pass_bound: assert property (pass_go |-> state_q == ST_IDLE) // RULE2
      else $error("previous pass not finished when interval expired");
   a_aux_locked: assert property (!cfg_q[CFG_MAKER_BIT] |=> aux_source_select == AUX_SUPPLY_IN) // RULE3
      else $error("supply slot redirected outside maker mode");
   a_aux_follow: assert property (cfg_q[CFG_MAKER_BIT] |=> aux_source_select == $past(cfg_q[3:1])) // RULE4
      else $error("source field not applied in maker mode");
   a_fine_flag: assert property (store && chan_q == CH_SUPPLY |=> supply_fine_q == ($past(aux_q) >= AUX_LOOP_DAC)) // RULE5
      else $error("fine-step flag wrong for selected source");
   a_low_zero: assert property (rvalid_q && rd_addr_q >= REG_RESULT0 && rd_addr_q < REG_READY |-> rdata_q[7:0] == 8'h00) // RULE7
      else $error("result low byte not zero");
   a_result_store: assert property (store |=> result_q[$past(chan_q)] == $past(conv_data) && ready_q[$past(chan_q)]) // RULE14 RULE15
      else $error("result or fresh flag not updated");
   a_gain_ref: assert property (conv_start_q && chan_q == CH_TXP |-> tx_gain == $past(cfg_q[CFG_GAIN_BIT]) && bias_reference_polarity == $past(cfg_q[CFG_REFPOL_BIT])) // RULE9 RULE10
      else $error("transmit range or reference not applied");

   c_wrap: cover property (store && chan_q == CH_RXP);
   c_redirect: cover property (store && chan_q == CH_SUPPLY && aux_q == AUX_FAULT_DAC);
   c_cal_read: cover property (rvalid_q && rd_addr_q == REG_CAL_BASE && rready);

endmodule : adc_monitor_sequencer

`default_nettype wire

// [shared/adc_mon_pkg.sv]
/*
 * shared constants for the monitoring converter sequencer: register map,
 * field positions, channel and source codes, sequencing time.
 * assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package adc_mon_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 25000;  // 40 MHz
   localparam int unsigned TCONV_US      = 100;    // one full pass of five channels
   localparam int unsigned TCONV_CYCLES  = (TCONV_US * 1000000) / CLK_PERIOD_PS;

   // ------------------------------------------------------------------
   // channels, sources, sequencer states
   // ------------------------------------------------------------------
   localparam int unsigned NUM_CH = 5;
   typedef enum logic [2:0] {
      CH_TEMP   = 3'h0,
      CH_SUPPLY = 3'h1,
      CH_BIAS   = 3'h2,
      CH_TXP    = 3'h3,
      CH_RXP    = 3'h4
   } chan_e;

   localparam logic [2:0] AUX_SUPPLY_IN  = 3'h0;
   localparam logic [2:0] AUX_ANALOG_VDD = 3'h1;
   localparam logic [2:0] AUX_BIAS_OUT   = 3'h2;
   localparam logic [2:0] AUX_MOD_OUT    = 3'h3;
   localparam logic [2:0] AUX_LOOP_DAC   = 3'h4;  // first fine-step source
   localparam logic [2:0] AUX_MOD_DAC    = 3'h5;
   localparam logic [2:0] AUX_FAULT_DAC  = 3'h6;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_START = 2'h1,
      ST_WAIT  = 2'h2
   } seq_state_e;

   // bias full scale: code 255 at 300 mV across the sense resistor
   localparam int unsigned BIAS_FULL_SCALE_MV   = 300;
   localparam logic [7:0]  BIAS_FULL_SCALE_CODE = 8'hff;

   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_CONFIG   = 8'h00;
   localparam logic [7:0] REG_RESULT0  = 8'h04;  // temp, supply, bias, txp, rxp follow
   localparam logic [7:0] REG_READY    = 8'h18;
   localparam logic [7:0] REG_STATUS   = 8'h1c;
   localparam logic [7:0] REG_CAL_BASE = 8'h20;
   localparam int unsigned CAL_WORDS   = 9;     // 36 bytes of calibration constants

   localparam int unsigned CFG_MAKER_BIT  = 0;
   localparam int unsigned CFG_AUX_LSB    = 1;
   localparam int unsigned CFG_GAIN_BIT   = 4;
   localparam int unsigned CFG_REFPOL_BIT = 5;
   localparam logic [5:0]  CFG_RESET      = 6'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : adc_mon_pkg

// [hw/cal_store.sv]
/*
 * word store for calibration constants, byte-writable, registered read.
 * assumes a single clock; read data appear one edge after the address.
 */
`timescale 1ns/1ps
`default_nettype none

module cal_store #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 9,
   parameter int unsigned AW    = 4
) (
   input  wire logic               aclk,
   input  wire logic               we,
   input  wire logic [WIDTH/8-1:0] wstrb,
   input  wire logic [AW-1:0]      waddr,
   input  wire logic [WIDTH-1:0]   wdata,
   input  wire logic [AW-1:0]      raddr,
   output var  logic [WIDTH-1:0]   rdata_q
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   // ------------------------------------------------------------------
   // byte lanes
   // ------------------------------------------------------------------
   // one lane per byte so partial writes keep the other constants;
   // a single process keeps the array to one driver
   always_ff @(posedge aclk) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
         if (we && wstrb[b]) begin
            mem_q[waddr][8*b +: 8] <= wdata[8*b +: 8];
         end
      end
   end

   // registered read port
   always_ff @(posedge aclk) begin
      rdata_q <= mem_q[raddr];
   end

endmodule : cal_store

`default_nettype wire

// [verif/conv_model.sv]
/*
 * converter model for the far side of the sequencer: one code per request.
 * assumes conv_start pulses for one cycle; base and lat come from the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module conv_model (
   input  wire logic               aclk,
   input  wire logic               conv_start,
   input  wire adc_mon_pkg::chan_e conv_channel,
   input  wire logic [7:0]         base,
   input  wire logic [3:0]         lat,
   output var  logic               conv_done,
   output var  logic [7:0]         conv_data,
   output var  int                 overlap
);
   import adc_mon_pkg::*;

   logic [3:0] cnt_q;
   logic [2:0] ch_q;

   initial begin
      conv_done = 1'b0;
      conv_data = 8'h5a;
      overlap   = 0;
      cnt_q     = 4'h0;
      ch_q      = 3'h0;
   end

   // ---------------------------------------------------------------
   // one conversion at a time; data line toggles while not answering
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;  // no stale code between answers
      if (conv_start && cnt_q != 4'h0) begin
         overlap <= overlap + 1;  // a second request while busy
      end
      if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h1) begin
            conv_done <= 1'b1;
            conv_data <= base + 8'(8'h11 * ch_q);
         end
      end else if (conv_start) begin
         cnt_q <= lat;
         ch_q  <= conv_channel;
      end
   end
endmodule : conv_model

`default_nettype wire

// [verif/test_adc_monitor_sequencer.sv]
/*
 * self-checking bench for the sequencer: axi4-lite master tasks, a channel
 * order monitor and a converter model. assumes a short pass interval.
 */
`timescale 1ns/1ps
`default_nettype none

module test_adc_monitor_sequencer;
   import adc_mon_pkg::*;
   localparam int unsigned CI = 60;  // short pass keeps the run brief

   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr, base;
   logic [31:0] wdata;
   logic [3:0]  wstrb, lat;
   wire logic   awready, wready, bvalid, arready, rvalid, conv_start;
   wire logic   tx_gain, pol, conv_done;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [2:0]  aux;
   wire logic [7:0]  conv_data;
   wire chan_e       conv_channel;
   int          failures, n_compared, overlap, cyc, gap;
   logic [2:0]  exp_ch;
   logic        seen;
   logic [31:0] cal [9];

   adc_monitor_sequencer #(.CONV_INTERVAL(CI)) DUT (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .conv_start(conv_start), .conv_channel(conv_channel),
      .aux_source_select(aux), .tx_gain(tx_gain), .bias_reference_polarity(pol),
      .conv_done(conv_done), .conv_data(conv_data));
   conv_model partner (.aclk(aclk), .conv_start(conv_start), .conv_channel(conv_channel),
      .base(base), .lat(lat), .conv_done(conv_done), .conv_data(conv_data),
      .overlap(overlap));

   always #12.5 aclk = ~aclk;

   // ---------------------------------------------------------------
   // shared checks and bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   // address and data offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
      logic aw, w;
      aw = 1'b1;
      w  = 1'b1;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
         if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
         if (bvalid) begin r = bresp; bready <= 1'b0; break; end
      end
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
      end
   endtask : axr

   // channel order, wrap and pass spacing seen at the converter link
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin failures++; conclude(); end
      if (!aresetn) begin exp_ch <= 3'h0; seen <= 1'b0; gap <= 0; end
      else begin
         gap <= gap + 1;
         if (conv_start === 1'b1) begin
            chk("channel", {29'h0, exp_ch}, {29'h0, conv_channel});
            exp_ch <= (exp_ch == 3'h4) ? 3'h0 : exp_ch + 3'h1;
            if (exp_ch == 3'h0) begin
               if (seen) chk("pass within interval", 1, {31'h0, gap <= CI});
               seen <= 1'b1;
               gap  <= 1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [2:0]  ax, ef;
      logic        mk, g, p;
      logic [7:0]  bad [4];
      aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
      rready = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; base = 8'h30; lat = 4'h2;
      failures = 0; n_compared = 0; cyc = 0;
      void'($urandom(32'h9be3d010));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axr(REG_CONFIG, d, r);
      chk("config reset", 32'h0, d);
      chk("aux after reset", 32'h0, {29'h0, aux});
      $display("test reset done");
      // every source code, with and without maker mode
      for (int i = 0; i < 14; i++) begin
         ax = 3'(i >> 1); mk = i[0]; g = 1'($urandom); p = 1'($urandom);
         ef = mk ? ax : 3'h0;
         axw(REG_CONFIG, {26'h0, p, g, ax, mk}, 4'h1, r);
         chk("config resp", RESP_OKAY, {30'h0, r});
         // steering outputs follow the config one edge after the response
         @(posedge aclk);
         chk("aux source", {29'h0, ef}, {29'h0, aux});
         chk("tx gain", {31'h0, g}, {31'h0, tx_gain});
         chk("ref polarity", {31'h0, p}, {31'h0, pol});
         repeat (2 * CI + 10) @(posedge aclk);
         axr(REG_STATUS, d, r);
         chk("status source", {28'h0, ef >= 3'h4, ef}, {28'h0, d[6:3]});
      end
      $display("test config done");
      // results, fast and slow converter, full-scale bias
      for (int k = 0; k < 6; k++) begin
         base <= (k == 0) ? 8'hdd : (k == 1) ? 8'h00 : 8'($urandom);
         lat  <= (k == 2) ? 4'h6 : 4'(1 + $urandom % 4);
         repeat (2 * CI + 10) @(posedge aclk);
         axr(REG_READY, d, r);
         chk("ready flags", 32'h1f, {27'h0, d[4:0]});
         for (int c = 0; c < NUM_CH; c++) begin
            axr(8'(REG_RESULT0 + 4 * c), d, r);
            chk("result", {16'h0, 8'(base + 8'(8'h11 * c)), 8'h00}, {16'h0, d[15:0]});
         end
      end
      $display("test results done");
      // read-only and unmapped places
      bad = '{REG_READY, REG_RESULT0, REG_STATUS, 8'h44};
      foreach (bad[j]) begin
         axw(bad[j], 32'hffffffff, 4'hf, r);
         chk("read-only write", RESP_SLVERR, {30'h0, r});
      end
      axr(8'h80, d, r);
      chk("unmapped resp", RESP_SLVERR, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      $display("test refusals done");
      // calibration words, one byte-masked
      axr(8'(REG_RESULT0 + 8), d, r);
      for (int w = 0; w < CAL_WORDS; w++) cal[w] = $urandom;
      cal[0] = 32'h01000000;
      cal[8] = {16'h0, 16'(-d[15:0])};
      for (int w = 0; w < CAL_WORDS; w++) axw(8'(REG_CAL_BASE + 4 * w), cal[w], 4'hf, r);
      axw(8'(REG_CAL_BASE + 12), 32'ha5c3e1f7, 4'h5, r);
      cal[3] = {cal[3][31:24], 8'hc3, cal[3][15:8], 8'hf7};
      for (int w = 0; w < CAL_WORDS; w++) begin
         axr(8'(REG_CAL_BASE + 4 * w), d, r);
         chk("calibration word", cal[w], d);
      end
      chk("one conversion at a time", 32'h0, 32'(overlap));
      $display("test calibration done");
      conclude();
   end
endmodule : test_adc_monitor_sequencer

`default_nettype wire
